//--- oei_consts.svh
/*
  Constants of the OTG event and interrupt logic: register addresses, bit positions,
  reset values and widths.
  Assumes inclusion by its bare name from the package, the checker and the bench.
*/
`ifndef OEI_CONSTS_SVH
`define OEI_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define OEI_ADDR_W 6
`define OEI_RISE_WR 6'h0d
`define OEI_RISE_SET 6'h0e
`define OEI_RISE_CLR 6'h0f
`define OEI_FALL_WR 6'h10
`define OEI_FALL_SET 6'h11
`define OEI_FALL_CLR 6'h12
`define OEI_STATUS 6'h13
`define OEI_LATCH 6'h14

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define OEI_NSRC 5
`define OEI_BIT_ID_GROUND 4
`define OEI_BIT_SESSION_END 3
`define OEI_BIT_SESSION_VALID 2
`define OEI_BIT_VBUS_VALID 1
`define OEI_BIT_HOST_DISCONNECT 0
`define OEI_EN_RESET 5'h1f
`define OEI_LATCH_RESET 5'h00

`endif

//--- oei_pkg.sv
/*
  Types of the OTG event and interrupt logic.
  Assumes oei_consts.svh is on the include path.
*/
package oei_pkg;
  `include "oei_consts.svh"

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic id_ground_detect;
    logic session_end_cmp;
    logic session_valid_cmp;
    logic vbus_valid_cmp;
    logic host_disconnect_detect;
  } oei_src_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`OEI_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } oei_req_t;

  typedef enum logic [1:0] {OEI_OP_WRITE, OEI_OP_SET, OEI_OP_CLEAR} oei_op_t;
endpackage

//--- oei_edge_enable.sv
/*
  One edge enable register with write, set and clear addresses.
  Assumes requests on the same clock as the register; reset is synchronous.
*/
module oei_edge_enable
  import oei_pkg::*;
#(
  parameter logic [`OEI_ADDR_W-1:0] WR_ADDR = `OEI_RISE_WR
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire oei_req_t req_i,
  output logic [`OEI_NSRC-1:0] en_o
);
  wire logic hit_wr;
  wire logic hit_set;
  wire logic hit_clr;
  wire logic [`OEI_NSRC-1:0] wbits;
  logic [`OEI_NSRC-1:0] next_en;

  assign wbits = req_i.wdata[`OEI_NSRC-1:0];
  assign hit_wr = req_i.wr && (req_i.addr == WR_ADDR);
  assign hit_set = req_i.wr && (req_i.addr == WR_ADDR + 6'h01);
  assign hit_clr = req_i.wr && (req_i.addr == WR_ADDR + 6'h02);

  // Reserved bits 7..5 are not stored, so they always read as zero.
  assign next_en = hit_wr ? wbits :
                   hit_set ? (en_o | wbits) :
                   hit_clr ? (en_o & ~wbits) : en_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_o <= `OEI_EN_RESET;
    end else begin
      en_o <= next_en;
    end
  end
endmodule // oei_edge_enable

//--- oei_event_logic.sv
/*
  Event and interrupt logic of a ULPI OTG transceiver: edge enables, live source
  status, sticky latch and the event pulse that asks the receive side for an RXCMD.
  Assumes all logic runs on the ULPI clock; the five source levels come from analog
  detectors and are synchronised here. Register requests come from the ULPI register
  engine as one-cycle strobes on the same clock.
*/
module oei_event_logic
  import oei_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire oei_src_t src_i,
  input wire oei_req_t req_i,
  input wire logic low_power_i,
  input wire logic serial_mode_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output oei_src_t rxcmd_level_o,
  output logic rxcmd_req_o,
  output logic [`OEI_NSRC-1:0] event_o
);
  // --------------------------------------------------------------------------
  // Source synchronisers
  // --------------------------------------------------------------------------
  logic [`OEI_NSRC-1:0] src_meta;
  logic [`OEI_NSRC-1:0] src_sync;
  logic [`OEI_NSRC-1:0] src_prev;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      src_meta <= '0;
      src_sync <= '0;
      src_prev <= '0;
    end else begin
      src_meta <= src_i;
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  // --------------------------------------------------------------------------
  // Edge enable registers
  // --------------------------------------------------------------------------
  wire logic [`OEI_NSRC-1:0] rise_en;
  wire logic [`OEI_NSRC-1:0] fall_en;

  oei_edge_enable #(.WR_ADDR(`OEI_RISE_WR)) u_rise (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .en_o(rise_en)
  );

  oei_edge_enable #(.WR_ADDR(`OEI_FALL_WR)) u_fall (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .en_o(fall_en)
  );

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  wire logic [`OEI_NSRC-1:0] rose;
  wire logic [`OEI_NSRC-1:0] fell;
  wire logic [`OEI_NSRC-1:0] unmasked;
  wire logic any_event;

  assign rose = src_sync & ~src_prev;
  assign fell = ~src_sync & src_prev;
  assign unmasked = (rose & rise_en) | (fell & fall_en);
  assign any_event = |unmasked;

  // --------------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------------
  function automatic logic [7:0] oei_pad(input logic [`OEI_NSRC-1:0] v);
    oei_pad = {3'h0, v};
  endfunction

  wire logic rd_rise;
  wire logic rd_fall;
  wire logic rd_status;
  wire logic rd_latch;
  wire logic [7:0] next_rdata;

  assign rd_rise = req_i.rd && (req_i.addr >= `OEI_RISE_WR) && (req_i.addr <= `OEI_RISE_CLR);
  assign rd_fall = req_i.rd && (req_i.addr >= `OEI_FALL_WR) && (req_i.addr <= `OEI_FALL_CLR);
  assign rd_status = req_i.rd && (req_i.addr == `OEI_STATUS);
  assign rd_latch = req_i.rd && (req_i.addr == `OEI_LATCH);

  // --------------------------------------------------------------------------
  // Sticky latch
  // --------------------------------------------------------------------------
  logic [`OEI_NSRC-1:0] latch;
  wire logic clear_all;
  wire logic [`OEI_NSRC-1:0] next_latch;

  // The read returns the old value; an event in the read cycle survives it.
  assign clear_all = rd_latch || low_power_i || serial_mode_i;
  assign next_latch = (clear_all ? '0 : latch) | unmasked;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      latch <= `OEI_LATCH_RESET;
    end else begin
      latch <= next_latch;
    end
  end

  // Unmapped reads return zero, matching the reserved-space behaviour.
  assign next_rdata = rd_rise ? oei_pad(rise_en) :
                      rd_fall ? oei_pad(fall_en) :
                      rd_status ? oei_pad(src_sync) :
                      rd_latch ? oei_pad(latch) : 8'h00;

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      rxcmd_level_o <= '0;
      rxcmd_req_o <= 1'b0;
      event_o <= '0;
    end else begin
      rdata_o <= next_rdata;
      rvalid_o <= req_i.rd;
      rxcmd_level_o <= src_sync;
      rxcmd_req_o <= any_event;
      event_o <= unmasked;
    end
  end
endmodule // oei_event_logic

//--- oei_checker.sv
/* Port checker of the OTG event logic.
   Assumes it is bound to the event logic and shares its clock and reset. */
`include "oei_consts.svh"
module oei_checker
  import oei_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire oei_src_t src_i,
  input wire oei_req_t req_i,
  input wire logic low_power_i,
  input wire logic serial_mode_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire oei_src_t rxcmd_level_o,
  input wire logic rxcmd_req_o,
  input wire logic [`OEI_NSRC-1:0] event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic rd_latch = req_i.rd && req_i.addr == `OEI_LATCH;
  wire logic rd_status = req_i.rd && req_i.addr == `OEI_STATUS;
  sequence quiet_reread;
    rd_latch ##1 (event_o == 0) [*2] ##1 (rd_latch && event_o == 0);
  endsequence
  chk_edge_origin: assert property ($past(rst_n_i, 5) && event_o != 0
    |-> (event_o & ~($past(src_i, 3) ^ $past(src_i, 4))) == 0) else $error("event without edge");
  chk_rxcmd_match: assert property (rxcmd_req_o == (event_o != 0))
    else $error("rxcmd and event disagree");
  chk_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("read unanswered");
  chk_reserved_zero: assert property (rvalid_o |-> rdata_o[7:5] == 3'h0)
    else $error("reserved bits set");
  chk_status_live: assert property ($past(rst_n_i, 3) && rd_status && $stable(src_i)
    && src_i == $past(src_i, 3) |=> rdata_o == {3'h0, $past(src_i)}) else $error("status wrong");
  chk_power_clear: assert property ($past(low_power_i || serial_mode_i) && rd_latch
    && event_o == 0 |=> rdata_o == 8'h00) else $error("latch kept in low power");
  chk_read_clear: assert property (quiet_reread |=> rdata_o == 8'h00)
    else $error("latch kept after read");
  chk_unmapped_zero: assert property (req_i.rd && (req_i.addr < 6'h0d || req_i.addr > 6'h14)
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule // oei_checker

bind oei_event_logic oei_checker chk_u (.clk_i, .rst_n_i, .src_i, .req_i, .low_power_i,
  .serial_mode_i, .rdata_o, .rvalid_o, .rxcmd_level_o, .rxcmd_req_o, .event_o);

//--- oei_link_model.sv
/* Link side model: counts the RXCMD requests it is sent.
   Assumes the clock and synchronous reset of the device. */
module oei_link_model
  import oei_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rxcmd_req_i,
  input wire oei_src_t rxcmd_level_i,
  output int rx_count_o
);
  // The link learns of changes from RXCMDs alone, so it never polls the latch.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) rx_count_o <= 0;
    else if (rxcmd_req_i) rx_count_o <= rx_count_o + 1;
  end
endmodule // oei_link_model

//--- tb_top.sv
/* Bench of the OTG event logic with a register and edge model.
   Assumes the package, checker and link model are compiled first. */
`include "oei_consts.svh"
module tb_top
  import oei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, low_power_i, serial_mode_i, rvalid_o, rxcmd_req_o;
  oei_src_t src_i, rxcmd_level_o;
  oei_req_t req_i;
  logic [7:0] rdata_o, got;
  logic [5:0] a;
  logic [4:0] event_o, evacc, nw, so, ex, lat;
  int failures, checks_done, seed, rx_count, n_ev, b, v;
  int en[2];
  oei_event_logic dut_u (.clk_i, .rst_n_i, .src_i, .req_i, .low_power_i, .serial_mode_i,
    .rdata_o, .rvalid_o, .rxcmd_level_o, .rxcmd_req_o, .event_o);
  oei_link_model link_u (.clk_i, .rst_n_i, .rxcmd_req_i(rxcmd_req_o),
    .rxcmd_level_i(rxcmd_level_o), .rx_count_o(rx_count));
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) evacc <= evacc | event_o;
  task automatic chk(input logic [7:0] seen, input logic [7:0] expd);
    checks_done++;
    if (seen !== expd) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic bus(input logic r, input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{rd: r, wr: !r, addr: ad, wdata: d};
    @(posedge clk_i);
    req_i <= '0;
    #1 got = rdata_o;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    results();
  end
  initial begin
    seed = 32'h9d32;
    {src_i, req_i, low_power_i, serial_mode_i, rst_n_i, so, lat} = '0;
    en = '{32'h1f, 32'h1f};
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1;
    for (b = 0; b < 2; b++) begin
      for (int k = 0; k < 3; k++) begin
        a = 6'((b ? `OEI_FALL_WR : `OEI_RISE_WR) + k);
        if (k == 0) bus(1, a, 8'h00);
        if (k == 0) chk(got, 8'h1f);
        v = $random(seed);
        bus(0, a, v[7:0]);
        en[b] = k == 0 ? v & 32'h1f : k == 1 ? en[b] | v & 32'h1f : en[b] & ~v & 32'h1f;
        bus(1, a, 8'h00);
        chk(got, 8'(en[b]));
      end
    end
    bus(1, `OEI_LATCH, 8'h00);
    chk(got, 8'h00);
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      bus(0, `OEI_RISE_WR, v[7:0]);
      bus(0, `OEI_FALL_WR, v[15:8]);
      nw = v[20:16];
      ex = (v[4:0] & nw & ~so) | (v[12:8] & ~nw & so);
      evacc = '0;
      @(posedge clk_i);
      src_i <= nw;
      repeat (6) @(posedge clk_i);
      chk({3'h0, evacc}, {3'h0, ex});
      chk({3'h0, rxcmd_level_o}, {3'h0, nw});
      lat = lat | ex;
      n_ev += (ex != 0);
      if (i % 4 == 3) begin
        bus(1, `OEI_LATCH, 8'h00);
        chk(got, {3'h0, lat});
        bus(1, `OEI_LATCH, 8'h00);
        chk(got, 8'h00);
        lat = '0;
      end
      bus(1, `OEI_STATUS, 8'h00);
      chk(got, {3'h0, nw});
      so = nw;
    end
    chk(8'(rx_count), 8'(n_ev));
    bus(0, `OEI_RISE_WR, 8'hff);
    bus(0, `OEI_FALL_WR, 8'hff);
    for (b = 0; b < 2; b++) begin
      so = ~so;
      @(posedge clk_i);
      src_i <= so;
      repeat (6) @(posedge clk_i);
      if (b) serial_mode_i <= 1;
      else low_power_i <= 1;
      bus(1, `OEI_LATCH, 8'h00);
      chk(got, 8'h00);
      @(posedge clk_i);
      {low_power_i, serial_mode_i} <= 2'h0;
    end
    bus(1, 6'h15, 8'h00);
    chk(got, 8'h00);
    bus(0, `OEI_FALL_WR, 8'h00);
    @(posedge clk_i);
    rst_n_i <= 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    bus(1, `OEI_FALL_CLR, 8'h00);
    chk(got, 8'h1f);
    results();
  end
endmodule // tb_top
